// ===== pkg/dsi_pkg.sv
package dsi_pkg;

  // Device/Head write selects this device when its device-select bit matches.
  localparam int unsigned DEV_BIT_POS      = 4;
  localparam int unsigned DATA_W           = 16;

  // Host register addresses as seen on the address pins with chip selects.
  localparam logic [2:0]  ADDR_STATUS_CMD  = 3'h7;
  localparam logic [2:0]  ADDR_DEVHEAD     = 3'h6;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned INTRQ_RESP_NS    = 400;
  localparam int unsigned INTRQ_MIN_PULSE_NS = 40;
  localparam int unsigned INTRQ_RESP_CYC   =
    (INTRQ_RESP_NS / CLK_PERIOD_NS) < 1 ? 1 : INTRQ_RESP_NS / CLK_PERIOD_NS;
  localparam int unsigned INTRQ_PULSE_CYC  =
    (INTRQ_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W      = 4;

  // Reset values.
  localparam logic        DEV_SEL_RST      = 1'b0;
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RST = 4'h0;

  typedef enum logic [1:0] {
    DSI_DMA_IDLE = 2'b00,
    DSI_DMA_REQ  = 2'b01,
    DSI_DMA_ACK  = 2'b10
  } dsi_dma_e;

endpackage : dsi_pkg

// ===== logic/dsi_core.sv
`timescale 1ns/1ns

// Contract
// - Raise the DMA request whenever the device is ready to move DMA data.
// - Hold the DMA request until acknowledge is seen, then drop; re-raise later.
// - During DMA the chip selects stay negated and transfers are 16 bits.
// - Release DMA request, interrupt and ready/strobe line while not selected.
// - Drive interrupt only when enabled and selected; it shows interrupt pending.
// - Release interrupt when disable bit is set or the device is deselected.
// - Status register read clears pending; interrupt drops within 400 ns.
// - Command register write clears pending; interrupt drops within 400 ns.
// - Device/Head write selecting us with pending set drives interrupt within 400 ns.
// - Device/Head write deselecting us releases interrupt within 400 ns.
// - Interrupt pulse racing with disable lasts at least 40 ns.
// - Negate ready to stretch host register cycles while not able to answer.
// - PIO modes 3 and up use the ready line to stretch cycles.
// - In data-out bursts assert device ready to accept, negate it to pause.
// - In data-in bursts toggle the device strobe per word; withhold edges to pause.
// - Device 1 asserts passed-diagnostics once its diagnostics finish.
// - Release passed-diagnostics by completion of the first command after reset.
// - Device number is 0 with cable select negated and 1 with it asserted.
// - Keep an interrupt pending flag set by events; drive only when enabled.
// - Latch the data bus on both edges of the host strobe in data-out bursts.
module dsi_core
  import dsi_pkg::*;
#(
  parameter int unsigned DW = dsi_pkg::DATA_W
) (
  // Clock and reset.
  input  wire logic          sys_clk_i,
  input  wire logic          nrst_i,
  // Host pins, all asynchronous to sys_clk_i.
  input  wire logic          cs0_n_i,
  input  wire logic          cs1_n_i,
  input  wire logic [2:0]    da_i,
  input  wire logic          dior_n_i,
  input  wire logic          diow_n_i,
  input  wire logic          dmack_n_i,
  input  wire logic          csel_n_i,
  input  wire logic [DW-1:0] dd_i,
  // Device-driven pins with output enables.
  output logic               dmarq_o,
  output logic               dmarq_oe_o,
  output logic               intrq_o,
  output logic               intrq_oe_o,
  output logic               iordy_o,
  output logic               iordy_oe_o,
  output logic               pdiag_n_o,
  output logic               pdiag_n_oe_o,
  output logic [DW-1:0]      dd_o,
  output logic               dd_oe_o,
  // Device-internal control.
  input  wire logic          irq_event_i,
  input  wire logic          nien_i,
  input  wire logic          dma_ready_i,
  input  wire logic          udma_out_i,
  input  wire logic          udma_in_i,
  input  wire logic          udma_accept_i,
  input  wire logic          in_valid_i,
  input  wire logic [DW-1:0] in_data_i,
  input  wire logic          reg_busy_i,
  input  wire logic          diag_done_i,
  input  wire logic          cmd_done_i,
  // Device-internal status.
  output logic               in_ready_o,
  output logic               out_valid_o,
  output logic [DW-1:0]      out_data_o,
  output logic               dev_num_o,
  output logic               selected_o,
  output logic               irq_pending_o
);
  import dsi_pkg::*;

  typedef struct packed {
    logic [2:0]             rd_s;
    logic [2:0]             wr_s;
    logic [2:0]             ack_s;
    logic [2:0]             sel_s;
    logic [2:0]             cs0_s;
    logic [2:0]             cs1_s;
    logic [2:0]             a0_s;
    logic [2:0]             a1_s;
    logic [2:0]             a2_s;
    logic                   rd_ff;
    logic                   wr_ff;
    logic                   ack_ff;
    logic [2:0]             addr_ff;
    logic                   dev_ff;
    logic                   csel_ff;
    logic                   pend_ff;
    logic                   intrq_ff;
    logic [PULSE_CNT_W-1:0] pulse_ff;
    dsi_dma_e               dma_ff;
    logic                   strobe_ff;
    logic [DW-1:0]          dout_ff;
    logic                   oval_ff;
    logic [DW-1:0]          odat_ff;
    logic                   pdiag_ff;
    logic                   firstcmd_ff;
  } dsi_state_s;

  dsi_state_s st_ff;
  dsi_state_s nxt_st;

  // A level counts once the second and third stages agree.
  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[1] : prev;
  endfunction : settle

  logic rd_now, wr_now, ack_now, csel_now, rd_end, wr_end, any_sel;
  logic [2:0] a_now;
  logic strobe_edge;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_s  = {st_ff.rd_s[1:0],  ~dior_n_i};
    nxt_st.wr_s  = {st_ff.wr_s[1:0],  ~diow_n_i};
    nxt_st.ack_s = {st_ff.ack_s[1:0], ~dmack_n_i};
    nxt_st.sel_s = {st_ff.sel_s[1:0], ~csel_n_i};
    nxt_st.cs0_s = {st_ff.cs0_s[1:0], ~cs0_n_i};
    nxt_st.cs1_s = {st_ff.cs1_s[1:0], ~cs1_n_i};
    nxt_st.a0_s  = {st_ff.a0_s[1:0],  da_i[0]};
    nxt_st.a1_s  = {st_ff.a1_s[1:0],  da_i[1]};
    nxt_st.a2_s  = {st_ff.a2_s[1:0],  da_i[2]};

    rd_now   = settle(st_ff.rd_s, st_ff.rd_ff);
    wr_now   = settle(st_ff.wr_s, st_ff.wr_ff);
    ack_now  = settle(st_ff.ack_s, st_ff.ack_ff);
    csel_now = settle(st_ff.sel_s, st_ff.csel_ff);
    a_now    = {settle(st_ff.a2_s, st_ff.addr_ff[2]), settle(st_ff.a1_s, st_ff.addr_ff[1]),
                settle(st_ff.a0_s, st_ff.addr_ff[0])};
    nxt_st.rd_ff   = rd_now;
    nxt_st.wr_ff   = wr_now;
    nxt_st.ack_ff  = ack_now;
    nxt_st.csel_ff = csel_now;
    // Address is only trusted while a strobe is active; decode uses the held copy.
    if (rd_now || wr_now) begin
      nxt_st.addr_ff = a_now;
    end
    // Command block access needs chip select 0; during DMA both stay negated.
    any_sel = st_ff.cs0_s[2] && !st_ff.cs1_s[2] && !st_ff.ack_ff;
    rd_end  = st_ff.rd_ff && !rd_now && any_sel;
    wr_end  = st_ff.wr_ff && !wr_now && any_sel;

    // Device/Head write updates the select bit; takes effect at strobe end.
    if (wr_end && st_ff.addr_ff == ADDR_DEVHEAD) begin
      nxt_st.dev_ff = dd_i[DEV_BIT_POS];
    end

    // Event set wins over a clear in the same cycle.
    if ((rd_end || wr_end) && st_ff.addr_ff == ADDR_STATUS_CMD &&
        (st_ff.dev_ff == st_ff.csel_ff)) begin
      nxt_st.pend_ff = 1'b0;
    end
    if (irq_event_i) begin
      nxt_st.pend_ff = 1'b1;
    end

    // Interrupt line: a fresh assertion is held for the minimum pulse even if disabled.
    nxt_st.intrq_ff = st_ff.pend_ff;
    if (st_ff.pend_ff && !st_ff.intrq_ff) begin
      nxt_st.pulse_ff = PULSE_CNT_W'(INTRQ_PULSE_CYC);
    end else if (st_ff.pulse_ff != PULSE_CNT_RST) begin
      nxt_st.pulse_ff = st_ff.pulse_ff - 1'b1;
    end

    // DMA request handshake.
    unique case (st_ff.dma_ff)
      DSI_DMA_IDLE: begin
        if (dma_ready_i) begin
          nxt_st.dma_ff = DSI_DMA_REQ;
        end
      end
      DSI_DMA_REQ: begin
        if (ack_now) begin
          nxt_st.dma_ff = DSI_DMA_ACK;
        end
      end
      DSI_DMA_ACK: begin
        if (!ack_now) begin
          nxt_st.dma_ff = DSI_DMA_IDLE;
        end
      end
      default: nxt_st.dma_ff = DSI_DMA_IDLE;
    endcase

    // Ultra DMA data-in: one strobe edge per word, no edge pauses the burst.
    strobe_edge = udma_in_i && st_ff.ack_ff && in_valid_i;
    if (strobe_edge) begin
      nxt_st.strobe_ff = ~st_ff.strobe_ff;
      nxt_st.dout_ff   = in_data_i;
    end

    // Ultra DMA data-out: every host strobe edge (seen on the read pin) takes a word.
    nxt_st.oval_ff = 1'b0;
    // Only the filtered level is used, since the first stage may still be settling.
    if (udma_out_i && st_ff.ack_ff && (rd_now != st_ff.rd_ff)) begin
      nxt_st.oval_ff = 1'b1;
      nxt_st.odat_ff = dd_i;
    end

    // Passed diagnostics as device 1, released by the first finished command.
    if (diag_done_i && csel_now && st_ff.firstcmd_ff) begin
      nxt_st.pdiag_ff = 1'b1;
    end
    if (cmd_done_i) begin
      nxt_st.pdiag_ff    = 1'b0;
      nxt_st.firstcmd_ff = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff             <= '0;
      st_ff.dev_ff      <= DEV_SEL_RST;
      st_ff.pulse_ff    <= PULSE_CNT_RST;
      st_ff.dma_ff      <= DSI_DMA_IDLE;
      st_ff.firstcmd_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  logic sel;
  assign sel = (st_ff.dev_ff == st_ff.csel_ff);

  // Sideband drive; all but passed-diagnostics released while this device is not selected.
  assign dmarq_o    = (st_ff.dma_ff == DSI_DMA_REQ);
  assign dmarq_oe_o = sel;
  assign intrq_o    = st_ff.intrq_ff || (st_ff.pulse_ff != PULSE_CNT_RST);
  assign intrq_oe_o = sel && (!nien_i || st_ff.pulse_ff != PULSE_CNT_RST);
  // Ready doubles as device-ready and data-in strobe in Ultra DMA.
  assign iordy_o    = udma_in_i  ? st_ff.strobe_ff :
                      udma_out_i ? !udma_accept_i :
                      !reg_busy_i;
  assign iordy_oe_o = sel;
  assign pdiag_n_o    = 1'b0;
  assign pdiag_n_oe_o = st_ff.pdiag_ff;
  assign dd_o         = st_ff.dout_ff;
  assign dd_oe_o      = sel && udma_in_i && st_ff.ack_ff;
  assign in_ready_o   = udma_in_i && st_ff.ack_ff;
  assign out_valid_o  = st_ff.oval_ff;
  assign out_data_o   = st_ff.odat_ff;
  assign dev_num_o    = st_ff.csel_ff;
  assign selected_o   = sel;
  assign irq_pending_o = st_ff.pend_ff;

  // The response budget is far above the synchroniser latency, so checks are loose bounds.
  AST_DMARQ_HOLD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (dmarq_o && !st_ff.ack_ff) |=> dmarq_o || st_ff.ack_ff)
    else $error("DMA request dropped before acknowledge");
  AST_DMARQ_RISE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st_ff.dma_ff == DSI_DMA_IDLE && dma_ready_i) |=> dmarq_o)
    else $error("DMA request not raised when ready");
  AST_REL_DESEL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !sel |-> !dmarq_oe_o && !intrq_oe_o && !iordy_oe_o)
    else $error("Pin driven while deselected");
  AST_INTRQ_NIEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (nien_i && st_ff.pulse_ff == PULSE_CNT_RST) |-> !intrq_oe_o)
    else $error("Interrupt driven while disabled");
  AST_PEND_SET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    irq_event_i |=> irq_pending_o ##1 intrq_o)
    else $error("Event did not reach interrupt");
  AST_PULSE_MIN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(intrq_o) |-> intrq_o [*5])
    else $error("Interrupt pulse shorter than 40 ns");
  AST_CLR_FAST: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (!irq_event_i && !nxt_st.pend_ff && irq_pending_o) |=> ##[0:8] !intrq_o)
    else $error("Interrupt not negated within 400 ns");
  AST_PDIAG_REL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cmd_done_i |=> !pdiag_n_oe_o)
    else $error("Passed diagnostics not released");
  AST_DEVNUM: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st_ff.sel_s == 3'b111) |=> dev_num_o)
    else $error("Device number does not follow cable select");

  AST_INTRQ_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (sel && !nien_i) |-> intrq_oe_o)
    else $error("Interrupt released while enabled and selected");

  AST_INTRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (irq_pending_o && $past(irq_pending_o)) |-> intrq_o)
    else $error("Interrupt low while pending");

  AST_DMARQ_DROP: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st_ff.dma_ff == DSI_DMA_REQ && ack_now) |=> !dmarq_o)
    else $error("DMA request kept after acknowledge");

  AST_DMARQ_WAIT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (dmarq_o && !ack_now) |=> dmarq_o)
    else $error("DMA request dropped without acknowledge");

  AST_IORDY_PIO: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (!udma_in_i && !udma_out_i) |-> iordy_o == !reg_busy_i)
    else $error("Ready line does not follow busy");

  AST_IORDY_PAUSE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (udma_out_i && !udma_in_i) |-> iordy_o == !udma_accept_i)
    else $error("Device ready does not follow accept");

  AST_STROBE_EDGE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (udma_in_i && st_ff.ack_ff && in_valid_i) |=> (!udma_in_i || iordy_o != $past(iordy_o)))
    else $error("No strobe edge for a data-in word");

  AST_STROBE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (udma_in_i && !in_valid_i) |=> (!udma_in_i || $stable(iordy_o)))
    else $error("Strobe edge without a data-in word");

  AST_DIN_DATA: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (udma_in_i && st_ff.ack_ff && in_valid_i) |=> dd_o == $past(in_data_i))
    else $error("Data-in word not on the bus");

  AST_DD_DESEL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !sel |-> !dd_oe_o)
    else $error("Data bus driven while deselected");

  AST_OUT_SRC: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    out_valid_o |-> $past(udma_out_i) && $past(st_ff.ack_ff))
    else $error("Data-out word outside a burst");

  AST_PDIAG_SET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (diag_done_i && csel_now && st_ff.firstcmd_ff && !cmd_done_i) |=> pdiag_n_oe_o)
    else $error("Passed diagnostics not asserted");

  AST_PDIAG_DEV1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(pdiag_n_oe_o) |-> dev_num_o)
    else $error("Passed diagnostics asserted as device 0");

  AST_PDIAG_ONCE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !st_ff.firstcmd_ff |-> !pdiag_n_oe_o)
    else $error("Passed diagnostics after first command");

  AST_DEVHEAD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_end && st_ff.addr_ff == ADDR_DEVHEAD) |=> st_ff.dev_ff == $past(dd_i[DEV_BIT_POS]))
    else $error("Device select bit not taken");

  AST_CLR_PEND: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ((rd_end || wr_end) && st_ff.addr_ff == ADDR_STATUS_CMD && sel && !irq_event_i)
    |=> !irq_pending_o)
    else $error("Pending not cleared by access");

  AST_INTRQ_SEL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ($rose(sel) && !nien_i) |-> intrq_oe_o)
    else $error("Interrupt not driven on selection");

  AST_DMA_NOREG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    st_ff.ack_ff |-> !rd_end && !wr_end)
    else $error("Register access taken during DMA");

  AST_DEVNUM_0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st_ff.sel_s == 3'b000) |=> !dev_num_o)
    else $error("Device number not 0 with cable select negated");

endmodule : dsi_core

// ===== tb/dsi_host_model.sv
`timescale 1ns/1ns

module dsi_host_model
  import dsi_pkg::*;
(
  // Clock and device-driven pins.
  input  wire logic              sys_clk_i,
  input  wire logic              dmarq_i,
  input  wire logic              iordy_i,
  // Host-driven pins.
  output logic                   cs0_n_o,
  output logic                   cs1_n_o,
  output logic [2:0]             da_o,
  output logic                   dior_n_o,
  output logic                   diow_n_o,
  output logic                   dmack_n_o,
  output logic [DATA_W-1:0]      dd_o
);
  int n_tmo = 0;

  initial begin
    {cs0_n_o, cs1_n_o, dior_n_o, diow_n_o, dmack_n_o} = 5'h1F;
    da_o = 3'h0;
    dd_o = 16'h0000;
  end

  // Strobes last six cycles so the device's three-flop filter always sees them.
  task automatic reg_acc(input logic [2:0] a, input logic wr, input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    cs0_n_o = 1'b0;
    da_o = a;
    dd_o = d;
    if (wr) diow_n_o = 1'b0;
    else dior_n_o = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1;
    dior_n_o = 1'b1;
    diow_n_o = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    cs0_n_o = 1'b1;
    dd_o = ~d;
  endtask : reg_acc

  task automatic dma_start();
    int n;
    n = 0;
    while (dmarq_i !== 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 100) n_tmo++;
    #1;
    dmack_n_o = 1'b0;
  endtask : dma_start

  // The host strobe toggles only inside the burst; it stands still between bursts.
  task automatic udma_out(input logic [15:0] w [$]);
    int n;
    #3;
    foreach (w[i]) begin
      n = 0;
      while (iordy_i !== 1'b0 && n < 200) begin
        #10;
        n++;
      end
      if (n >= 200) n_tmo++;
      dd_o = w[i];
      #8;
      dior_n_o = ~dior_n_o;
      #32;
    end
    dd_o = ~dd_o;
  endtask : udma_out

  task automatic dma_end();
    @(posedge sys_clk_i);
    #1;
    dmack_n_o = 1'b1;
  endtask : dma_end
endmodule : dsi_host_model

// ===== tb/disk_interface_signal_logic_test.sv
`timescale 1ns/1ns

module disk_interface_signal_logic_test;
  import dsi_pkg::*;
  localparam int RB = INTRQ_RESP_CYC - 4;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i, cs0_n_i, cs1_n_i, dior_n_i, diow_n_i, dmack_n_i, csel_n_i;
  logic [2:0]  da_i;
  logic [15:0] dd_i, in_data_i, out_data_o, dd_o, seed;
  logic        dmarq_o, dmarq_oe_o, intrq_o, intrq_oe_o, iordy_o, iordy_oe_o;
  logic        pdiag_n_o, pdiag_n_oe_o, dd_oe_o, in_ready_o, out_valid_o;
  logic        dev_num_o, selected_o, irq_pending_o, irq_event_i, nien_i, dma_ready_i;
  logic        udma_out_i, udma_in_i, udma_accept_i, in_valid_i;
  logic        reg_busy_i, diag_done_i, cmd_done_i;
  logic [15:0] exp_q [$];
  logic [15:0] got_q [$];
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_in = 0;

  always #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;

  dsi_core i_dsi_core (.sys_clk_i, .nrst_i, .cs0_n_i, .cs1_n_i, .da_i, .dior_n_i, .diow_n_i,
    .dmack_n_i, .csel_n_i, .dd_i, .dmarq_o, .dmarq_oe_o, .intrq_o, .intrq_oe_o, .iordy_o,
    .iordy_oe_o, .pdiag_n_o, .pdiag_n_oe_o, .dd_o, .dd_oe_o, .irq_event_i, .nien_i,
    .dma_ready_i, .udma_out_i, .udma_in_i, .udma_accept_i, .in_valid_i, .in_data_i,
    .reg_busy_i, .diag_done_i, .cmd_done_i, .in_ready_o, .out_valid_o, .out_data_o,
    .dev_num_o, .selected_o, .irq_pending_o);

  dsi_host_model i_dsi_host_model (.sys_clk_i, .dmarq_i(dmarq_o), .iordy_i(iordy_o),
    .cs0_n_o(cs0_n_i), .cs1_n_o(cs1_n_i), .da_o(da_i), .dior_n_o(dior_n_i),
    .diow_n_o(diow_n_i), .dmack_n_o(dmack_n_i), .dd_o(dd_i));

  always @(posedge sys_clk_i) if (out_valid_o === 1'b1) got_q.push_back(out_data_o);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic sig(input int k);
    case (k)
      0: return intrq_o;
      1: return intrq_oe_o;
      2: return dmarq_o;
      3: return selected_o;
      4: return dev_num_o;
      default: return pdiag_n_oe_o;
    endcase
  endfunction : sig

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step

  // Waits are bounded; a wait that runs out shows up as a mismatch in chk.
  task automatic wt(input int k, input logic v, input int b);
    int n;
    n = 0;
    while (sig(k) !== v && n < b) begin
      step(1);
      n++;
    end
    chk(16'(sig(k)), 16'(v));
  endtask : wt

  task automatic pulse(input int k);
    step(1);
    case (k)
      0: irq_event_i = 1'b1;
      1: diag_done_i = 1'b1;
      default: cmd_done_i = 1'b1;
    endcase
    step(1);
    {irq_event_i, diag_done_i, cmd_done_i} = 3'h0;
  endtask : pulse

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {nrst_i, irq_event_i, nien_i, dma_ready_i, udma_out_i, udma_in_i} = 6'h00;
    {udma_accept_i, in_valid_i, reg_busy_i, diag_done_i, cmd_done_i} = 5'h00;
    in_data_i = 16'h0000;
    csel_n_i = 1'b1;
    seed = 16'hDAC9;
    step(4);
    nrst_i = 1'b1;
    chk(16'({irq_pending_o, dmarq_o}), 16'h0);
    wt(4, 1'b0, 8);
    i_dsi_host_model.reg_acc(ADDR_DEVHEAD, 1'b1, 16'h0000);
    wt(3, 1'b1, 16);
    pulse(0);
    wt(0, 1'b1, RB);
    chk(16'(intrq_oe_o), 16'h1);
    nien_i = 1'b1;
    wt(1, 1'b0, RB);
    nien_i = 1'b0;
    i_dsi_host_model.reg_acc(ADDR_STATUS_CMD, 1'b0, 16'h0000);
    wt(0, 1'b0, RB);
    pulse(0);
    wt(0, 1'b1, RB);
    i_dsi_host_model.reg_acc(ADDR_STATUS_CMD, 1'b1, 16'h00EC);
    wt(0, 1'b0, RB);
    chk(16'(irq_pending_o), 16'h0);
    pulse(0);
    i_dsi_host_model.reg_acc(ADDR_DEVHEAD, 1'b1, 16'h0010);
    wt(1, 1'b0, RB);
    chk(16'({dmarq_oe_o, iordy_oe_o}), 16'h0);
    i_dsi_host_model.reg_acc(ADDR_DEVHEAD, 1'b1, 16'h0000);
    wt(1, 1'b1, RB);
    for (int i = 0; i < 4; i++) begin
      reg_busy_i = seed[0];
      seed = lfsr(seed);
      step(3);
      chk(16'(iordy_o), 16'(!reg_busy_i));
    end
    dma_ready_i = 1'b1;
    wt(2, 1'b1, 8);
    step(10);
    chk(16'(dmarq_o), 16'h1);
    i_dsi_host_model.dma_start();
    dma_ready_i = 1'b0;
    wt(2, 1'b0, 16);
    udma_out_i = 1'b1;
    udma_accept_i = 1'b1;
    step(3);
    chk(16'(iordy_o), 16'h0);
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(seed);
      seed = lfsr(seed);
    end
    fork
      i_dsi_host_model.udma_out(exp_q);
      begin
        step(12);
        udma_accept_i = 1'b0;
        step(20);
        udma_accept_i = 1'b1;
      end
    join
    step(10);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    udma_out_i = 1'b0;
    udma_in_i  = 1'b1;
    for (int i = 0; i < 8; i++) begin
      in_valid_i = seed[1];
      in_data_i  = seed;
      seed       = lfsr(seed);
      step(1);
      n_in += int'(in_valid_i);
      chk(16'(iordy_o), 16'(n_in % 2));
      chk(16'({dd_oe_o, in_ready_o}), 16'h3);
      if (in_valid_i) chk(dd_o, in_data_i);
    end
    {udma_in_i, in_valid_i} = 2'h0;
    i_dsi_host_model.dma_end();
    udma_out_i = 1'b0;
    csel_n_i = 1'b0;
    wt(4, 1'b1, 8);
    wt(3, 1'b0, 8);
    i_dsi_host_model.reg_acc(ADDR_DEVHEAD, 1'b1, 16'h0010);
    wt(3, 1'b1, 16);
    pulse(1);
    wt(5, 1'b1, 16);
    chk(16'(pdiag_n_o), 16'h0);
    pulse(2);
    wt(5, 1'b0, 16);
    chk(16'(i_dsi_host_model.n_tmo), 16'h0);
    tally_and_finish();
  end
endmodule : disk_interface_signal_logic_test
